// ### hdl/sud_bit_if.sv
// sud_bit_if.sv: receive-side destuffed bit stream between delimiter modules
// assumes: single clock domain
`timescale 1ns/1ps
`default_nettype none
interface sud_bit_if;
    logic bit_valid;
    logic bit_data;
    logic flag_seen;
    logic abort_seen;
    modport src (output bit_valid, output bit_data, output flag_seen, output abort_seen);
    modport dst (input bit_valid, input bit_data, input flag_seen, input abort_seen);
endinterface
`default_nettype wire

// ### hdl/sud_delimiter.sv
// sud_delimiter.sv: signal unit delimitation and alignment, both directions
// assumes: serial pins sampled at clk; one bit per strobe; no registers
//
// Function
// (R1) every unit is opened and closed by a unique eight-bit flag.
// (R2) the sender stuffs contents so the flag never appears inside a unit.
// (R3) more than six ones in a row on receive declares loss of alignment.
// (R4) a unit longer than the maximum before its closing flag declares loss.
// (R5) loss of alignment is shown to the error rate monitor while it lasts.
// (R6) the flag pattern is zero, six ones, zero, on both ends.
// (R7) one flag may close one unit and open the next.
// (R8) a zero follows five ones on send and is removed on receive.
`timescale 1ns/1ps
`default_nettype none
`include "sud_map.svh"
module sud_delimiter
    import sud_pkg::*;
#(
    parameter int MAX_OCTETS = 273
)(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // serial line receive
    input  wire logic       rx_strobe_pin,
    input  wire logic       rx_bit_pin,
    // receive octets to upper logic
    output logic            rx_oct_valid,
    output logic [7:0]      rx_oct_data,
    output logic            rx_unit_end,
    output logic            rx_unit_bad,
    // alignment status to error rate monitor
    output logic            align_lost,
    // transmit octets from upper logic
    input  wire logic       tx_oct_valid,
    input  wire logic [7:0] tx_oct_data,
    input  wire logic       tx_oct_last,
    output logic            tx_oct_ready,
    // serial line transmit
    input  wire logic       tx_strobe,
    output logic            tx_bit
);
    // ****************************************
    // elaboration check
    // ****************************************
    if (MAX_OCTETS < 6 || MAX_OCTETS > 511) begin : g_bad_max
        $error("MAX_OCTETS out of range");
    end

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [1:0] sy_stb_reg, sy_bit_reg;
    logic       stb_d_reg;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sy_stb_reg <= 2'b00;
            sy_bit_reg <= 2'b00;
            stb_d_reg  <= 1'b0;
        end else begin
            sy_stb_reg <= {sy_stb_reg[0], rx_strobe_pin};
            sy_bit_reg <= {sy_bit_reg[0], rx_bit_pin};
            stb_d_reg  <= sy_stb_reg[1];
        end
    end
    logic rx_stb;
    // rising edge of synchronised strobe, bit taken with it
    assign rx_stb = sy_stb_reg[1] & ~stb_d_reg;

    sud_bit_if bits();
    sud_rx_destuff u_destuff (
        .clk       (clk),
        .reset_n   (reset_n),
        .rx_strobe (rx_stb),
        .rx_bit    (sy_bit_reg[1]),
        .out       (bits.src)
    );

    // ****************************************
    // receive octet assembly and alignment
    // ****************************************
    logic [7:0] acc_reg,   acc_next;
    logic [2:0] nbit_reg,  nbit_next;
    logic [8:0] noct_reg,  noct_next;
    logic       inunit_reg, inunit_next;
    logic       lost_reg,  lost_next;
    logic       ov_reg, ov_next, end_reg, end_next, bad_reg, bad_next;
    logic [7:0] od_reg, od_next;

    always_comb begin
        acc_next = acc_reg;
        nbit_next = nbit_reg;
        noct_next = noct_reg;
        inunit_next = inunit_reg;
        lost_next = lost_reg;
        ov_next = 1'b0;
        od_next = od_reg;
        end_next = 1'b0;
        bad_next = 1'b0;
        // (R3) forbidden ones run
        if (bits.abort_seen) begin
            lost_next = 1'b1;
            inunit_next = 1'b0;
            bad_next = inunit_reg;
        end else if (bits.flag_seen) begin
            // (R7) closing flag also opens next unit
            if (inunit_reg && noct_reg != 9'h000) begin
                end_next = 1'b1;
                bad_next = (nbit_reg != 3'h0) || (noct_reg < `SUD_MIN_OCTETS);
            end
            // (R1) flag found, unit boundary
            inunit_next = 1'b1;
            lost_next = 1'b0;
            nbit_next = 3'h0;
            noct_next = 9'h000;
        end else if (bits.bit_valid && inunit_reg) begin
            acc_next = {bits.bit_data, acc_reg[7:1]};
            nbit_next = nbit_reg + 3'h1;
            if (nbit_reg == 3'h7) begin
                // (R4) over-length unit
                if (noct_reg >= 9'(MAX_OCTETS)) begin
                    lost_next = 1'b1;
                    inunit_next = 1'b0;
                    bad_next = 1'b1;
                end else begin
                    ov_next = 1'b1;
                    od_next = {bits.bit_data, acc_reg[7:1]};
                    noct_next = noct_reg + 9'h001;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_reg <= 8'h00;
            nbit_reg <= 3'h0;
            noct_reg <= 9'h000;
            inunit_reg <= 1'b0;
            lost_reg <= 1'b1;
            ov_reg <= 1'b0;
            od_reg <= 8'h00;
            end_reg <= 1'b0;
            bad_reg <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            nbit_reg <= nbit_next;
            noct_reg <= noct_next;
            inunit_reg <= inunit_next;
            lost_reg <= lost_next;
            ov_reg <= ov_next;
            od_reg <= od_next;
            end_reg <= end_next;
            bad_reg <= bad_next;
        end
    end

    assign rx_oct_valid = ov_reg;
    assign rx_oct_data  = od_reg;
    assign rx_unit_end  = end_reg;
    assign rx_unit_bad  = bad_reg;
    // (R5) level to error rate monitor
    assign align_lost   = lost_reg;

    // ****************************************
    // transmit flagging and zero insertion
    // ****************************************
    sud_tx_state_t st_reg, st_next;
    logic [7:0] sh_reg,  sh_next;
    logic [2:0] cnt_reg, cnt_next;
    logic [2:0] ones_reg, ones_next;
    logic       last_reg, last_next, rdy_reg, rdy_next, bit_reg, bit_next;

    always_comb begin
        st_next = st_reg;
        sh_next = sh_reg;
        cnt_next = cnt_reg;
        ones_next = ones_reg;
        last_next = last_reg;
        bit_next = bit_reg;
        rdy_next = 1'b0;
        if (tx_strobe) begin
            case (st_reg)
                SUD_TX_FLAG: begin
                    // (R6) send flag lsb first
                    bit_next = 1'(`SUD_FLAG >> cnt_reg);
                    ones_next = 3'h0;
                    cnt_next = cnt_reg + 3'h1;
                    if (cnt_reg == 3'h7 && tx_oct_valid) begin
                        // (R7) one flag between units
                        st_next = SUD_TX_DATA;
                        sh_next = tx_oct_data;
                        last_next = tx_oct_last;
                        rdy_next = 1'b1;
                    end
                end
                SUD_TX_DATA: begin
                    bit_next = sh_reg[0];
                    sh_next = {1'b0, sh_reg[7:1]};
                    ones_next = sh_reg[0] ? ones_reg + 3'h1 : 3'h0;
                    cnt_next = cnt_reg + 3'h1;
                    // (R2) (R8) stuff after five ones
                    if (sh_reg[0] && ones_reg == 3'h4)
                        st_next = SUD_TX_STUF;
                    else if (cnt_reg == 3'h7)
                        st_next = SUD_TX_DATA;
                    if (cnt_reg == 3'h7 && !(sh_reg[0] && ones_reg == 3'h4)) begin
                        if (last_reg || !tx_oct_valid) begin
                            st_next = SUD_TX_FLAG;
                        end else begin
                            sh_next = tx_oct_data;
                            last_next = tx_oct_last;
                            rdy_next = 1'b1;
                        end
                    end
                end
                SUD_TX_STUF: begin
                    bit_next = 1'b0;
                    ones_next = 3'h0;
                    st_next = SUD_TX_DATA;
                    if (cnt_reg == 3'h0) begin
                        if (last_reg || !tx_oct_valid) begin
                            st_next = SUD_TX_FLAG;
                        end else begin
                            sh_next = tx_oct_data;
                            last_next = tx_oct_last;
                            rdy_next = 1'b1;
                        end
                    end
                end
                default: st_next = SUD_TX_FLAG;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= SUD_TX_FLAG;
            sh_reg <= 8'h00;
            cnt_reg <= 3'h0;
            ones_reg <= 3'h0;
            last_reg <= 1'b0;
            rdy_reg <= 1'b0;
            bit_reg <= 1'b1;
        end else begin
            st_reg <= st_next;
            sh_reg <= sh_next;
            cnt_reg <= cnt_next;
            ones_reg <= ones_next;
            last_reg <= last_next;
            rdy_reg <= rdy_next;
            bit_reg <= bit_next;
        end
    end

    // ready is a one-cycle pulse in the cycle after the take; data must be valid before it
    assign tx_oct_ready = rdy_reg;
    assign tx_bit = bit_reg;
endmodule // sud_delimiter
`default_nettype wire

// ### hdl/sud_map.svh
// sud_map.svh: offsets-free constants for the signal unit delimiter
// assumes: included by the design files by bare name
`ifndef SUD_MAP_SVH
`define SUD_MAP_SVH

`define SUD_FLAG          8'h7e
`define SUD_ONES_ABORT    4'h7
`define SUD_ONES_STUFF    4'h5
`define SUD_FLAG_LEAD     3'h7
`define SUD_MAX_OCTETS    9'h111
`define SUD_MIN_OCTETS    9'h005

`endif

// ### hdl/sud_pkg.sv
// sud_pkg.sv: types shared by the delimiter modules
// assumes: nothing beyond sud_map.svh
package sud_pkg;
    typedef enum logic [1:0] {
        SUD_TX_FLAG = 2'b00,
        SUD_TX_DATA = 2'b01,
        SUD_TX_STUF = 2'b10
    } sud_tx_state_t;
endpackage

// ### hdl/sud_rx_destuff.sv
// sud_rx_destuff.sv: flag detection, ones-run check and zero deletion
// assumes: rx bit already synchronised, one bit per rx_strobe
`timescale 1ns/1ps
`default_nettype none
`include "sud_map.svh"
module sud_rx_destuff
    import sud_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // incoming bit
    input  wire logic rx_strobe,
    input  wire logic rx_bit,
    // destuffed stream
    sud_bit_if.src    out
);
    logic [6:0] dly_reg,   dly_next;
    logic [2:0] fill_reg,  fill_next;
    logic [3:0] ones_reg,  ones_next;
    logic       keep;
    logic       v_next, d_next, f_next, a_next;
    logic       v_reg, d_reg, f_reg, a_reg;

    always_comb begin
        dly_next   = dly_reg;
        fill_next  = fill_reg;
        ones_next  = ones_reg;
        keep   = 1'b0;
        v_next = 1'b0;
        d_next = d_reg;
        f_next = 1'b0;
        a_next = 1'b0;
        if (rx_strobe) begin
            if (rx_bit) begin
                ones_next = (ones_reg == `SUD_ONES_ABORT) ? ones_reg : ones_reg + 4'h1;
                // (R3) seventh one aborts
                if (ones_reg == 4'h6)
                    a_next = 1'b1;
                else
                    keep = 1'b1;
            end else begin
                ones_next = 4'h0;
                // (R6) flag is 0 111111 0
                if (ones_reg == 4'h6)
                    f_next = 1'b1;
                // (R8) drop stuffed zero
                else if (ones_reg < `SUD_ONES_STUFF)
                    keep = 1'b1;
            end
        end
        // (R7) flag lead-in bits held back
        // seven bits of latency buy a clean octet boundary at every flag
        if (f_next || a_next) begin
            fill_next = 3'h0;
        end else if (keep) begin
            dly_next = {rx_bit, dly_reg[6:1]};
            if (fill_reg == `SUD_FLAG_LEAD) begin
                v_next = 1'b1;
                d_next = dly_reg[0];
            end else begin
                fill_next = fill_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dly_reg   <= 7'h00;
            fill_reg  <= 3'h0;
            ones_reg  <= 4'h0;
            v_reg <= 1'b0;
            d_reg <= 1'b0;
            f_reg <= 1'b0;
            a_reg <= 1'b0;
        end else begin
            dly_reg   <= dly_next;
            fill_reg  <= fill_next;
            ones_reg  <= ones_next;
            v_reg <= v_next;
            d_reg <= d_next;
            f_reg <= f_next;
            a_reg <= a_next;
        end
    end

    assign out.bit_valid  = v_reg;
    assign out.bit_data   = d_reg;
    assign out.flag_seen  = f_reg;
    assign out.abort_seen = a_reg;
endmodule // sud_rx_destuff
`default_nettype wire

// ### verification/sud_delimiter_props.sv
// sud_delimiter_props.sv: port-level checks on the signal unit delimiter
// assumes: bound to sud_delimiter, one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module sud_delimiter_props (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // line side
    input wire logic rx_strobe_pin,
    input wire logic rx_bit_pin,
    input wire logic tx_strobe,
    input wire logic tx_bit,
    // user side
    input wire logic rx_oct_valid,
    input wire logic rx_unit_end,
    input wire logic align_lost,
    input wire logic tx_oct_valid,
    input wire logic tx_oct_ready
);
    // ****************
    // line trackers
    // ****************
    logic [2:0] stb_reg;
    logic [1:0] bit_reg;
    logic [1:0] txs_reg;
    logic [3:0] ones_reg;
    logic [3:0] tx_ones_reg;
    logic [7:0] hist_reg;
    logic [3:0] flag_age_reg;
    logic       edge_seen;
    logic       flag_now;
    // same two-stage sync as the design, so edges line up
    assign edge_seen = stb_reg[1] & ~stb_reg[2];
    assign flag_now  = edge_seen && ({bit_reg[1], hist_reg[7:1]} == 8'h7e);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stb_reg      <= 3'h0;
            bit_reg      <= 2'h0;
            txs_reg      <= 2'h0;
            ones_reg     <= 4'h0;
            tx_ones_reg  <= 4'h0;
            hist_reg     <= 8'h00;
            flag_age_reg <= 4'hf;
        end else begin
            stb_reg      <= {stb_reg[1:0], rx_strobe_pin};
            bit_reg      <= {bit_reg[0], rx_bit_pin};
            txs_reg      <= {txs_reg[0], tx_strobe};
            flag_age_reg <= flag_now ? 4'h0 : (flag_age_reg == 4'hf ? 4'hf : flag_age_reg + 4'h1);
            if (edge_seen) begin
                hist_reg <= {bit_reg[1], hist_reg[7:1]};
                ones_reg <= !bit_reg[1] ? 4'h0 : (ones_reg == 4'hf ? 4'hf : ones_reg + 4'h1);
            end
            if (txs_reg[1]) begin
                tx_ones_reg <= !tx_bit ? 4'h0 : (tx_ones_reg == 4'hf ? 4'hf : tx_ones_reg + 4'h1);
            end
        end
    end
    // ****************
    // assertions
    // ****************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_SEVEN_ONES:
        assert property (edge_seen && bit_reg[1] && ones_reg == 4'h6 |-> ##[1:8] align_lost)
        else $error("no loss of alignment after seven ones");
    AST_FLAG_CLEARS:
        assert property (flag_now |-> ##[1:8] !align_lost)
        else $error("loss of alignment kept after a flag");
    AST_TX_ONES:
        assert property (tx_ones_reg <= 4'h6) else $error("more than six ones sent");
    AST_READY_CAUSE:
        assert property (tx_oct_ready |-> $past(tx_oct_valid) && $past(tx_strobe))
        else $error("octet taken without offer and strobe");
    AST_READY_SPACE:
        assert property (tx_oct_ready |=> !tx_oct_ready [*7]) else $error("octets taken too close");
    AST_OCT_SPACE:
        assert property (rx_oct_valid |=> !rx_oct_valid [*8]) else $error("octets received too close");
    AST_END_AFTER_FLAG:
        assert property (rx_unit_end |-> flag_age_reg <= 4'h8) else $error("unit end without flag");
    AST_TX_STABLE:
        assert property (!$past(tx_strobe) && !$past(tx_strobe, 2) |-> $stable(tx_bit))
        else $error("line bit moved without strobe");
endmodule // sud_delimiter_props
bind sud_delimiter sud_delimiter_props u_sud_delimiter_props (.clk(clk), .reset_n(reset_n),
    .rx_strobe_pin(rx_strobe_pin), .rx_bit_pin(rx_bit_pin), .tx_strobe(tx_strobe),
    .tx_bit(tx_bit), .rx_oct_valid(rx_oct_valid), .rx_unit_end(rx_unit_end),
    .align_lost(align_lost), .tx_oct_valid(tx_oct_valid), .tx_oct_ready(tx_oct_ready));
`default_nettype wire

// ### verification/sud_far_end.sv
// sud_far_end.sv: remote terminal model, echoes our line or sends raw bits
// assumes: same clock as the design; one line bit every 8 clocks
`timescale 1ns/1ps
`default_nettype none
module sud_far_end (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // line
    input  wire logic tx_bit,
    output logic      tx_strobe,
    output logic      rx_strobe_pin,
    output logic      rx_bit_pin,
    // raw bits from the bench
    input  wire logic raw_en,
    input  wire logic raw_bit,
    output logic      slot
);
    // ****************
    // bit timing
    // ****************
    logic [2:0] cnt_reg;
    assign slot = (cnt_reg == 3'h0);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg       <= 3'h0;
            tx_strobe     <= 1'b0;
            rx_strobe_pin <= 1'b0;
            rx_bit_pin    <= 1'b1;
        end else begin
            cnt_reg       <= cnt_reg + 3'h1;
            tx_strobe     <= (cnt_reg == 3'h7);
            rx_strobe_pin <= (cnt_reg >= 3'h3) && (cnt_reg <= 3'h5);
            if (cnt_reg == 3'h2) begin
                rx_bit_pin <= raw_en ? raw_bit : tx_bit;
            end
        end
    end
endmodule // sud_far_end
`default_nettype wire

// ### verification/tb_sud_delimiter.sv
// tb_sud_delimiter.sv: looped-back delimiter with raw line injection
// assumes: far end model echoes the line; checker bound separately
`timescale 1ns/1ps
`default_nettype none
module tb_sud_delimiter;
    localparam int MAXO = 8;
    logic clk = 0, reset_n = 0, tx_oct_valid = 0, tx_oct_last = 0, raw_en = 0, raw_bit = 0;
    logic [7:0] tx_oct_data = 8'h00, rx_oct_data;
    logic rx_oct_valid, rx_unit_end, rx_unit_bad, align_lost, tx_oct_ready, tx_strobe, tx_bit;
    logic rx_strobe_pin, rx_bit_pin, slot, lost_d = 1;
    logic [31:0] lfsr = 32'h500f2a07;
    logic [7:0] rxq[$], expq[$];
    int n_fail = 0, n_checks = 0, n_lost = 0, n_clr = 0, n_end = 0, n_bad = 0;
    always #5 clk = ~clk;
    sud_delimiter #(.MAX_OCTETS(MAXO)) u_sud_delimiter (.clk(clk), .reset_n(reset_n),
        .rx_strobe_pin(rx_strobe_pin), .rx_bit_pin(rx_bit_pin), .rx_oct_valid(rx_oct_valid),
        .rx_oct_data(rx_oct_data), .rx_unit_end(rx_unit_end), .rx_unit_bad(rx_unit_bad),
        .align_lost(align_lost), .tx_oct_valid(tx_oct_valid), .tx_oct_data(tx_oct_data),
        .tx_oct_last(tx_oct_last), .tx_oct_ready(tx_oct_ready), .tx_strobe(tx_strobe),
        .tx_bit(tx_bit));
    sud_far_end u_sud_far_end (.clk(clk), .reset_n(reset_n), .tx_bit(tx_bit),
        .tx_strobe(tx_strobe), .rx_strobe_pin(rx_strobe_pin), .rx_bit_pin(rx_bit_pin),
        .raw_en(raw_en), .raw_bit(raw_bit), .slot(slot));
    // ****************
    // monitor and helpers
    // ****************
    always @(posedge clk) if (reset_n) begin
        if (rx_oct_valid === 1'b1) rxq.push_back(rx_oct_data);
        if (rx_unit_end === 1'b1) n_end++;
        if (rx_unit_bad === 1'b1) n_bad++;
        if (align_lost === 1'b1 && !lost_d) n_lost++;
        if (align_lost === 1'b0 && lost_d) n_clr++;
        lost_d = (align_lost === 1'b1);
    end
    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wait_for(ref int c, input int target);
        int k;
        for (k = 0; k < 3000 && c < target; k++) @(posedge clk);
        if (c < target) begin
            check("timeout", 0, 1);
            give_verdict();
        end
    endtask
    // offer octets lsb first; caller drops valid so units can abut
    task automatic send_unit(int n, logic [7:0] first);
        int k, j;
        logic [7:0] d;
        for (k = 0; k < n; k++) begin
            lfsr = lfsr_next(lfsr);
            d = (k == 0) ? first : lfsr[7:0];
            expq.push_back(d);
            tx_oct_valid <= 1'b1;
            tx_oct_data <= d;
            tx_oct_last <= (k == n - 1);
            for (j = 0; j < 600 && tx_oct_ready !== 1'b1; j++) @(posedge clk);
            if (tx_oct_ready !== 1'b1) begin
                check("ready_timeout", 0, 1);
                give_verdict();
            end
            @(posedge clk);
        end
    endtask
    task automatic raw_send(logic [15:0] bits, int n);
        int k, j;
        for (k = 0; k < n; k++) begin
            for (j = 0; j < 9 && slot !== 1'b1; j++) @(negedge clk);
            @(posedge clk);
            raw_bit <= bits[k];
            @(negedge clk);
        end
    endtask
    // ****************
    // scenarios
    // ****************
    initial begin
        repeat (5) @(posedge clk);
        check("lost_in_reset", align_lost, 1);
        check("line_idle_reset", tx_bit, 1);
        reset_n <= 1'b1;
        wait_for(n_clr, 1);
        // three abutting units share flags, stuffing corners first
        send_unit(5, 8'hff);
        send_unit(5 + lfsr[1:0], 8'h7e);
        send_unit(MAXO, 8'h3f);
        tx_oct_valid <= 1'b0;
        wait_for(n_end, 3);
        check("units_lost", n_lost, 0);
        check("units_bad", n_bad, 0);
        check("oct_count", rxq.size(), expq.size());
        while (rxq.size() > 0 && expq.size() > 0) check("octet", rxq.pop_front(), expq.pop_front());
        send_unit(MAXO + 1, 8'h55);
        tx_oct_valid <= 1'b0;
        wait_for(n_lost, 1);
        wait_for(n_clr, 2);
        check("overlong_lost", n_lost, 1);
        check("overlong_bad", n_bad, 1);
        rxq.delete();
        expq.delete();
        // raw run of seven ones, then a flag restores
        @(posedge clk);
        raw_en <= 1'b1;
        raw_send(16'h00fe, 8);
        wait_for(n_lost, 2);
        check("ones_lost", align_lost, 1);
        raw_send(16'h007e, 8);
        wait_for(n_clr, 3);
        check("flag_clears", align_lost, 0);
        raw_send(16'h7e7e, 16);
        // let the last raw bits clear the synchronisers first
        repeat (40) @(posedge clk);
        check("six_ones_ok", n_lost, 2);
        give_verdict();
    end
endmodule // tb_sud_delimiter
`default_nettype wire
